// File: logic/spsd_pkg.sv
package spsd_pkg;

    // ****************************************
    // Register indices; byte address is four times the index.
    // ****************************************
    localparam logic [7:0] IDX_CONTROL = 8'hd4;
    localparam logic [7:0] IDX_STATUS = 8'hd5;
    localparam logic [7:0] IDX_DATA = 8'hd6;
    localparam int ADDR_W = 12;

    // ****************************************
    // Control register fields and reset value.
    // ****************************************
    localparam int CTRL_RATE_HI = 7;
    localparam int CTRL_EN = 6;
    localparam int CTRL_SELECT_PIN_DISABLE = 5;
    localparam int CTRL_MASTER_SELECT = 4;
    localparam int CTRL_CPOL = 3;
    localparam int CTRL_CPHA = 2;
    localparam int CTRL_RATE_MID = 1;
    localparam int CTRL_RATE_LO = 0;
    localparam logic [7:0] CTRL_RESET = 8'h14;

    // ****************************************
    // Status and control register fields.
    // ****************************************
    localparam int ST_DONE = 7;
    localparam int ST_RSVD = 6;
    localparam int ST_OVR = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;
    localparam int ST_TXE = 3;
    localparam int ST_LSB = 2;
    localparam int ST_TXE_IE = 1;
    localparam int ST_MODE_FAULT_FLAG_IE = 0;
    localparam logic ST_TXE_RESET = 1'b1;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ****************************************
    // Timing counts.
    // ****************************************
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] LAST_TOGGLE = 4'hf;
    localparam logic [6:0] HALF_MIN = 7'h02;
    localparam int PIN_COUNT = 4;

    typedef enum logic {SPSD_IDLE, SPSD_RUN} spsd_state_t;

endpackage

// File: logic/spsd_sync.sv
module spsd_sync
    import spsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [PIN_COUNT-1:0] d,
    output logic [PIN_COUNT-1:0] q
);

    logic [PIN_COUNT-1:0] stage;

    // ****************************************
    // Two flip-flops per pin against metastability.
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage <= '0;
            q <= '0;
        end
        else
        begin
            stage <= d;
            q <= stage;
        end
    end

endmodule

// File: logic/spsd_top.sv
// What this block does
// - Done flag bit 7, cleared when a master transfer starts.
// - Status read then data access clears done.
// - Overrun bit 5, keep old byte, read clears.
// - Mode fault bit 4, status read clears.
// - Slave fault: ignore data until select low.
// - Master fault clears peripheral enable.
// - Transmit empty bit 3 tracks register state.
// - Bit 2 selects LSB first, default MSB.
// - Empty enable routes empty, masks done request.
// - Bit 0 gates the mode fault request.
// - Bit 6 reserved, software writes zero.
// - Reset clears status bits 7, 6, 4.
// - Data write loads shift register directly while enabled and not busy.
// - Data read returns receive buffer.
// - Eight bit data register at index d6.
// - Enable clear stops transfer at once.
// - Deselected slave tristates, clears count, ignores clock.
// - Select disable suppresses mode fault request.
// - Slave select rise mid transmission is fault.
//
// Decided for this implementation: the APB register port.
module spsd_top
    import spsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic irq
);

    // ****************************************
    // Helper functions.
    // ****************************************
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        reg_hit = (a[ADDR_W-1:2] == {2'b00, idx});
    endfunction

    function automatic logic first_bit(input logic [7:0] s, input logic lsb);
        first_bit = lsb ? s[0] : s[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic lsb);
        shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
    endfunction

    function automatic logic [6:0] half_len(input logic [2:0] code);
        unique case (code)
            3'h1: half_len = 7'h02;
            3'h2: half_len = 7'h04;
            3'h3: half_len = 7'h08;
            3'h4: half_len = 7'h10;
            3'h5: half_len = 7'h20;
            3'h6: half_len = 7'h40;
            default: half_len = HALF_MIN;
        endcase
    endfunction

    // ****************************************
    // State.
    // ****************************************
    logic [PIN_COUNT-1:0] pins_s;
    logic sck_s, mosi_s, miso_s, ss_s;
    logic [7:0] ctrl;
    logic done_flag, ovr_flag, mode_fault_flag_flag, txe_flag;
    logic lsb_first, txe_ie, mode_fault_flag_ie;
    logic [7:0] rx_buf, shreg;
    logic out_bit;
    logic [2:0] bit_cnt;
    spsd_state_t state;
    logic [6:0] half_cnt;
    logic [3:0] toggles;
    logic sck_prev, ss_prev, slave_tx, status_armed;

    spsd_sync u_sync
    (
        .clk(pclk),
        .rst_n(presetn),
        .d({sck_in, mosi_in, miso_in, ss_n_in}),
        .q(pins_s)
    );
    assign {sck_s, mosi_s, miso_s, ss_s} = pins_s;

    // ****************************************
    // Decode and events.
    // ****************************************
    logic en, master_select, select_pin_disable, cpol, cpha;
    logic acc, wr, rd, sel_ctrl, sel_stat, sel_data, hit;
    logic slave_sel, m_tick, edge_ev, edge_lvl, lead, trail, sample, shift, din, done;
    logic busy, wr_data_ok, wr_data_bad, start, ss_rise, ss_fall, mode_fault_flag_set, done_clr, done_eff;
    logic run_end;
    logic [7:0] rx_byte;
    logic [7:0] status_word;
    logic [31:0] rd_word;

    assign en = ctrl[CTRL_EN];
    assign master_select = ctrl[CTRL_MASTER_SELECT];
    assign select_pin_disable = ctrl[CTRL_SELECT_PIN_DISABLE];
    assign cpol = ctrl[CTRL_CPOL];
    assign cpha = ctrl[CTRL_CPHA];

    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign sel_ctrl = reg_hit(paddr, IDX_CONTROL);
    assign sel_stat = reg_hit(paddr, IDX_STATUS);
    assign sel_data = reg_hit(paddr, IDX_DATA);
    assign hit = sel_ctrl | sel_stat | sel_data;

    // A slave with select disabled only ignores the pin when phase is one.
    assign slave_sel = en & ~master_select & ((select_pin_disable & cpha) | ~ss_s);
    assign m_tick = (state == SPSD_RUN) & (half_cnt == half_len({ctrl[CTRL_RATE_HI], ctrl[CTRL_RATE_MID],
        ctrl[CTRL_RATE_LO]}) - 7'h01);
    assign run_end = m_tick & (toggles == LAST_TOGGLE);
    assign edge_ev = master_select ? m_tick : (slave_sel & (sck_s != sck_prev));
    assign edge_lvl = master_select ? ~sck_out : sck_s;
    assign lead = edge_ev & (edge_lvl != cpol);
    assign trail = edge_ev & (edge_lvl == cpol);
    assign sample = cpha ? trail : lead;
    assign shift = cpha ? lead : trail;
    assign din = master_select ? miso_s : mosi_s;
    assign rx_byte = shift_in(shreg, din, lsb_first);
    assign done = sample & (bit_cnt == LAST_BIT);

    assign busy = (state == SPSD_RUN) | (slave_tx & (bit_cnt != 3'h0));
    assign wr_data_ok = wr & sel_data & ~busy;
    // A data write during a transfer is dropped and reported as overrun.
    assign wr_data_bad = wr & sel_data & busy;
    assign start = wr_data_ok & master_select & en;
    assign ss_rise = ss_s & ~ss_prev;
    assign ss_fall = ~ss_s & ss_prev;
    assign mode_fault_flag_set = (en & ~master_select & ~select_pin_disable & slave_tx & ss_rise)
        | (en & master_select & ~select_pin_disable & ~ss_s);
    assign done_clr = status_armed & acc & sel_data;
    assign done_eff = done_flag & ~done_clr;

    assign status_word = {done_flag, 1'b0, ovr_flag, mode_fault_flag_flag, txe_flag, lsb_first, txe_ie, mode_fault_flag_ie};

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (sel_ctrl)
        begin
            rd_word = {24'h00_0000, ctrl};
        end
        else if (sel_stat)
        begin
            rd_word = {24'h00_0000, status_word};
        end
        else if (sel_data)
        begin
            rd_word = {24'h00_0000, rx_buf};
        end
    end

    // ****************************************
    // APB slave: one wait cycle, then ready.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // ****************************************
    // Control register.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RESET;
        end
        else
        begin
            if (wr & sel_ctrl)
            begin
                ctrl <= pwdata[7:0];
            end
            if (en & master_select & ~select_pin_disable & ~ss_s)
            begin
                ctrl[CTRL_EN] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Status flags and software bits.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_flag <= 1'b0;
            ovr_flag <= 1'b0;
            mode_fault_flag_flag <= 1'b0;
            txe_flag <= ST_TXE_RESET;
            lsb_first <= 1'b0;
            txe_ie <= 1'b0;
            mode_fault_flag_ie <= 1'b0;
            status_armed <= 1'b0;
        end
        else
        begin
            if (wr & sel_stat)
            begin
                lsb_first <= pwdata[ST_LSB];
                txe_ie <= pwdata[ST_TXE_IE];
                mode_fault_flag_ie <= pwdata[ST_MODE_FAULT_FLAG_IE];
            end
            if (rd & sel_stat)
            begin
                status_armed <= 1'b1;
            end
            else if (acc & sel_data)
            begin
                status_armed <= 1'b0;
            end
            // Every set below follows its clear so that a coinciding event is kept.
            if (done_clr | start)
            begin
                done_flag <= 1'b0;
            end
            if (done & ~done_eff)
            begin
                done_flag <= 1'b1;
            end
            if (rd & sel_stat)
            begin
                ovr_flag <= 1'b0;
                mode_fault_flag_flag <= 1'b0;
            end
            if ((done & done_eff) | wr_data_bad)
            begin
                ovr_flag <= 1'b1;
            end
            if (mode_fault_flag_set)
            begin
                mode_fault_flag_flag <= 1'b1;
            end
            if (wr_data_ok)
            begin
                txe_flag <= 1'b0;
            end
            if (~en | (master_select ? run_end : done))
            begin
                txe_flag <= 1'b1;
            end
        end
    end

    // ****************************************
    // Receive buffer.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_buf <= DATA_RESET;
        end
        else if (done & ~done_eff)
        begin
            rx_buf <= rx_byte;
        end
    end

    // ****************************************
    // Shift engine shared by master and slave.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shreg <= DATA_RESET;
            out_bit <= 1'b0;
            bit_cnt <= 3'h0;
        end
        else if (~en)
        begin
            bit_cnt <= 3'h0;
        end
        else if (wr_data_ok)
        begin
            shreg <= pwdata[7:0];
            if (~cpha)
            begin
                out_bit <= first_bit(pwdata[7:0], lsb_first);
            end
        end
        else if (~master_select & ~slave_sel)
        begin
            bit_cnt <= 3'h0;
        end
        else
        begin
            if (sample)
            begin
                shreg <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (shift | (~master_select & ~cpha & ss_fall))
            begin
                out_bit <= first_bit(shreg, lsb_first);
            end
        end
    end

    // ****************************************
    // Master clock generator.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= SPSD_IDLE;
            half_cnt <= 7'h00;
            toggles <= 4'h0;
            sck_out <= 1'b0;
        end
        else if (~en | ~master_select)
        begin
            state <= SPSD_IDLE;
            sck_out <= cpol;
        end
        else
        begin
            unique case (state)
                SPSD_IDLE:
                begin
                    sck_out <= cpol;
                    if (start)
                    begin
                        state <= SPSD_RUN;
                        half_cnt <= 7'h00;
                        toggles <= 4'h0;
                    end
                end
                SPSD_RUN:
                begin
                    if (m_tick)
                    begin
                        sck_out <= ~sck_out;
                        half_cnt <= 7'h00;
                        toggles <= toggles + 4'h1;
                        if (run_end)
                        begin
                            state <= SPSD_IDLE;
                        end
                    end
                    else
                    begin
                        half_cnt <= half_cnt + 7'h01;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Slave select tracking.
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_prev <= 1'b0;
            ss_prev <= 1'b1;
            slave_tx <= 1'b0;
        end
        else
        begin
            sck_prev <= sck_s;
            ss_prev <= ss_s;
            if (~en | master_select | ss_rise | done)
            begin
                slave_tx <= 1'b0;
            end
            else if (ss_fall)
            begin
                slave_tx <= 1'b1;
            end
        end
    end

    // ****************************************
    // Pin enables and interrupt request.
    // ****************************************
    assign mosi_out = out_bit;
    assign miso_out = out_bit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            sck_oe <= en & master_select;
            mosi_oe <= en & master_select;
            miso_oe <= slave_sel;
            // The request is a level, so software must clear the flag or enable to drop it.
            irq <= (txe_ie ? txe_flag : done_flag)
                | (mode_fault_flag_ie & ~select_pin_disable & mode_fault_flag_flag);
        end
    end

endmodule

// File: tb/spsd_monitor.sv
module spsd_monitor
    import spsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Bus and request checks.
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic st_rd;
    assign st_rd = pready && !pwrite && paddr[11:2] == {2'b00, IDX_STATUS};
    ready_late_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_bus_a: assert property (pready |-> $past(penable)) else $error("pready without access");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
    rdata_upper_a: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    err_map_a: assert property (psel && penable && !pready |=>
        pslverr == (paddr[11:2] < 10'h0d4 || paddr[11:2] > 10'h0d6)) else $error("pslverr wrong");
    rsvd_zero_a: assert property (st_rd |-> prdata[6] == 1'b0) else $error("reserved bit set");
    irq_on_a: assert property (st_rd && (prdata[1] ? prdata[3] : prdata[7]) |-> irq) else $error("irq missing");
    irq_off_a: assert property (st_rd && !(prdata[1] ? prdata[3] : prdata[7]) && !(prdata[0] && prdata[4])
        |-> !irq) else $error("irq unexpected");
    oe_roles_a: assert property (mosi_oe == sck_oe && !(mosi_oe && miso_oe)) else $error("enables clash");
endmodule

// File: tb/spsd_slave_model.sv
module spsd_slave_model
(
    input wire logic clk,
    input wire logic sel,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Mode zero slave, selected while the master drives its clock.
    // ****
    logic [2:0] n = 3'h0;
    logic idle_pat = 1'b0;
    initial rx = 8'h00;
    // A released line toggles so that a stale bit can never pass for data.
    always @(posedge clk) idle_pat <= ~idle_pat;
    always @(posedge sck) if (sel) rx <= {rx[6:0], mosi};
    always @(negedge sck or negedge sel) n <= sel ? n + 3'h1 : 3'h0;
    assign miso = sel ? reply[3'h7 - n] : idle_pat;
endmodule

// File: tb/spsd_top_tb.sv
module spsd_top_tb
    import spsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, ss_n_in, sck_drv, mosi_drv, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq, m_miso;
    logic sck_w, mosi_w, miso_w;
    logic [7:0] reply, rx, r, tx, sb, got;
    logic [2:0] rc;
    int num_errors = 0;
    int checked = 0;
    assign sck_w = sck_oe ? sck_out : sck_drv;
    assign mosi_w = mosi_oe ? mosi_out : mosi_drv;
    assign miso_w = miso_oe ? miso_out : m_miso;
    spsd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .irq(irq));
    spsd_slave_model far (.clk(pclk), .sel(sck_oe), .sck(sck_w), .mosi(mosi_w), .reply(reply), .miso(m_miso), .rx(rx));
    // ****
    // Helpers.
    // ****
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The idle cycle at entry keeps back to back calls from driving psel twice in one step.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) chk("pready", 8'h1, 8'h0);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        apb(1'b0, IDX_STATUS, 8'h00);
        while (r[7] !== 1'b1 && n < 400)
        begin
            apb(1'b0, IDX_STATUS, 8'h00);
            n++;
        end
    endtask
    task automatic slave_byte(input logic [7:0] v);
        for (int k = 0; k < 8; k++)
        begin
            mosi_drv <= v[7 - k];
            repeat (4) @(posedge pclk);
            got[7 - k] = miso_w;
            sck_drv <= 1'b1;
            repeat (4) @(posedge pclk);
            sck_drv <= 1'b0;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #400us;
        chk("watchdog", 8'h0, 8'h1);
        report_and_stop();
    end
    // ****
    // Tests.
    // ****
    initial
    begin
        void'($urandom(32'h08749001));
        {psel, penable, pwrite, presetn, sck_drv, mosi_drv, paddr, pwdata, reply} = '0;
        ss_n_in = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("status reset", 8'h08, r);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk("control reset", 8'h14, r);
        apb(1'b0, IDX_DATA, 8'h00);
        chk("data reset", DATA_RESET, r);
        apb(1'b0, 8'h10, 8'h00);
        chk("unmapped", 8'h1, e);
        apb(1'b1, IDX_STATUS, 8'h02);
        repeat (2) @(posedge pclk);
        chk("irq empty", 8'h1, irq);
        $display("reset and register test finished");
        apb(1'b1, IDX_CONTROL, 8'h52);
        for (int i = 0; i < 5; i++)
        begin
            tx = (i == 0) ? 8'h01 : 8'($urandom);
            reply = (i == 1) ? 8'h80 : 8'($urandom);
            // Rates below divide by eight are left out: the far model turns data around too slowly.
            rc = 3'(2 + $urandom % 5);
            apb(1'b1, IDX_CONTROL, {rc[2], 5'b10100, rc[1:0]});
            apb(1'b1, IDX_STATUS, {5'h00, i[0], 2'b00});
            apb(1'b1, IDX_DATA, tx);
            if (i == 4) apb(1'b1, IDX_DATA, ~tx);
            apb(1'b0, IDX_STATUS, 8'h00);
            chk("busy flags", {1'b0, i == 4, 1'b0}, {r[7], r[5], r[3]});
            wait_done();
            // Empty only rises at the last clock toggle, up to one half period after done.
            repeat (70) @(posedge pclk);
            apb(1'b0, IDX_STATUS, 8'h00);
            chk("done flags", 8'h3, {r[7], r[3]});
            chk("irq done", 8'h1, irq);
            chk("wire byte", i[0] ? rev8(tx) : tx, rx);
            apb(1'b0, IDX_DATA, 8'h00);
            chk("rx data", i[0] ? rev8(reply) : reply, r);
            apb(1'b0, IDX_STATUS, 8'h00);
            chk("flags cleared", 8'h0, {r[7], r[5]});
        end
        $display("master transfer test finished");
        apb(1'b1, IDX_DATA, 8'h5a);
        apb(1'b1, IDX_CONTROL, 8'h12);
        repeat (100) @(posedge pclk);
        chk("clock off", 8'h0, sck_oe);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("aborted", 8'h0, r[7]);
        apb(1'b1, IDX_CONTROL, 8'h52);
        ss_n_in <= 1'b0;
        repeat (6) @(posedge pclk);
        ss_n_in <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("irq masked", 8'h0, irq);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk("enable off", 8'h12, r);
        apb(1'b1, IDX_STATUS, 8'h01);
        repeat (2) @(posedge pclk);
        chk("irq fault", 8'h1, irq);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("fault set", 8'h3, {r[4], r[0]});
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("fault cleared", 8'h0, r[4]);
        $display("master fault test finished");
        apb(1'b1, IDX_CONTROL, 8'h40);
        apb(1'b1, IDX_DATA, 8'hc3);
        sb = 8'($urandom);
        ss_n_in <= 1'b0;
        slave_byte(sb);
        chk("slave out", 8'hc3, got);
        repeat (4) @(posedge pclk);
        ss_n_in <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("miso off", 8'h0, miso_oe);
        wait_done();
        chk("slave done", 8'h2, {r[7], r[4]});
        apb(1'b0, IDX_DATA, 8'h00);
        chk("slave rx", sb, r);
        ss_n_in <= 1'b0;
        repeat (6) @(posedge pclk);
        ss_n_in <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("irq slave fault", 8'h1, irq);
        slave_byte(8'h3c);
        apb(1'b1, IDX_CONTROL, 8'h60);
        repeat (2) @(posedge pclk);
        chk("irq disabled", 8'h0, irq);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("ignored", 8'h1, {r[7], r[4]});
        $display("slave test finished");
        report_and_stop();
    end
endmodule

bind spsd_top spsd_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .irq(irq));
